/* File: sim/balu_evt_src.sv */
// io event source standing in for the peripherals
`timescale 1ns/1ps
`default_nettype none
module balu_evt_src (
    input  wire logic       clk,
    input  wire logic [7:0] req,      // bits to raise
    output logic      [7:0] io_event  // one pulse per request cycle
);
    // registered so the pulse never changes at the sampling edge
    always_ff @(posedge clk) io_event <= req;
endmodule
`default_nettype wire

/* File: sim/balu_top_sva.sv */
// bus and busy timing assertions for the byte alu
`timescale 1ns/1ps
`default_nettype none
module balu_top_chk (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        alu_busy
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------
    // data phase tracking
    // ----------------
    logic       w_q;  // write data phase
    logic       r_q;  // read data phase
    logic [7:0] a_q;  // offset of that phase
    logic       cmd;  // command write landing now
    assign cmd = w_q && a_q == 8'h00;
    // address phase taken whenever selected, ready and htrans[1] set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_q <= 1'b0;
            r_q <= 1'b0;
            a_q <= 8'h00;
        end else begin
            w_q <= hsel & hready & htrans[1] & hwrite;
            r_q <= hsel & hready & htrans[1] & ~hwrite;
            a_q <= haddr[7:0];
        end
    end
    // ----------------
    // assertions
    // ----------------
    ready_high_a: assert property (hreadyout) else $error("wait state seen");
    resp_okay_a: assert property (!hresp) else $error("error response");
    busy_start_a: assert property (cmd && !alu_busy |=> alu_busy) else $error("command lost");
    busy_min_a: assert property ($rose(alu_busy) |=> alu_busy) else $error("command too short");
    busy_max_a: assert property ($rose(alu_busy) |-> ##[2:3] !alu_busy) else $error("command too long");
    busy_idle_a: assert property (!alu_busy && !cmd |=> !alu_busy) else $error("busy unasked");
    stat_pad_a: assert property (r_q && a_q == 8'h08 |-> hrdata[31:2] == 30'h0) else $error("status pad");
    unmapped_zero_a: assert property (r_q && a_q > 8'h17 |-> hrdata == 32'h0) else $error("hole read");
endmodule
bind balu_top balu_top_chk balu_top_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .alu_busy(alu_busy));
`default_nettype wire

/* File: sim/testbench.sv */
// self-checking bench for the byte alu
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        hclk = 1'b0;     // 200 MHz
    logic        hresetn = 1'b0;  // held low at start
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout;
    logic        hresp;
    logic        alu_busy;
    logic [31:0] hrdata;
    logic [31:0] q;               // last read
    logic [31:0] stat;            // last status after a command
    logic [7:0]  req = 8'h00;     // io flag set request
    logic [7:0]  io_event;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cyc = 0;         // watchdog
    // op, rr, imm, rd preload, flags in, result, flags out {h,s,v,n,z,c}
    logic [53:0] tc [24] = '{
        {5'h00, 5'h10, 8'h00, 8'h0f, 6'h00, 16'h0010, 6'h20},
        {5'h01, 5'h10, 8'h00, 8'hff, 6'h01, 16'h0001, 6'h21},
        {5'h02, 5'h10, 8'h00, 8'h80, 6'h00, 16'h007f, 6'h38},
        {5'h03, 5'h10, 8'h00, 8'h01, 6'h01, 16'h00ff, 6'h35},
        {5'h04, 5'h00, 8'h10, 8'h10, 6'h00, 16'h0000, 6'h02},
        {5'h05, 5'h00, 8'h00, 8'h00, 6'h01, 16'h00ff, 6'h35},
        {5'h06, 5'h00, 8'h01, 8'hff, 6'h00, 16'h0100, 6'h00},
        {5'h07, 5'h00, 8'h01, 8'h00, 6'h00, 16'hffff, 6'h15},
        {5'h09, 5'h00, 8'h0f, 8'hf0, 6'h01, 16'h0000, 6'h03},
        {5'h0b, 5'h00, 8'h01, 8'h80, 6'h20, 16'h0081, 6'h34},
        {5'h0d, 5'h00, 8'h00, 8'h00, 6'h00, 16'h0000, 6'h02},
        {5'h0e, 5'h00, 8'h0f, 8'hff, 6'h00, 16'h00f0, 6'h14},
        {5'h0f, 5'h00, 8'h00, 8'h80, 6'h08, 16'h0080, 6'h14},
        {5'h17, 5'h10, 8'h00, 8'hff, 6'h00, 16'hffff, 6'h01},
        {5'h16, 5'h11, 8'h00, 8'hff, 6'h3e, 16'h7f80, 6'h3c},
        {5'h12, 5'h00, 8'h00, 8'h7f, 6'h01, 16'h0080, 6'h0d},
        {5'h08, 5'h11, 8'h00, 8'hc3, 6'h08, 16'h0080, 6'h14},
        {5'h0a, 5'h10, 8'h00, 8'h00, 6'h00, 16'h0001, 6'h00},
        {5'h0c, 5'h10, 8'h00, 8'h81, 6'h01, 16'h0080, 6'h15},
        {5'h10, 5'h00, 8'h00, 8'h55, 6'h00, 16'h00aa, 6'h15},
        {5'h11, 5'h00, 8'h00, 8'h01, 6'h00, 16'h00ff, 6'h35},
        {5'h13, 5'h00, 8'h00, 8'h80, 6'h01, 16'h007f, 6'h19},
        {5'h14, 5'h00, 8'h00, 8'h5a, 6'h24, 16'h0000, 6'h22},
        {5'h15, 5'h00, 8'h00, 8'h00, 6'h2a, 16'h00ff, 6'h2a}
    };
    balu_top balu_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .io_event(io_event), .alu_busy(alu_busy));
    balu_evt_src balu_evt_src_i (.clk(hclk), .req(req), .io_event(io_event));
    initial forever #2.5 hclk = ~hclk;
    // one single ahb transfer, held until ready seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // command write, then poll until busy drops
    task automatic op(input logic [4:0] o, input logic [4:0] d, input logic [5:0] r, input logic [7:0] k);
        bus(1'b1, 8'h00, {k, 2'h0, r, 3'h0, d, 3'h0, o}, stat);
        do bus(1'b0, 8'h08, 32'h0, stat); while (stat[0] !== 1'b0);
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // preload r25:r24, set flags, run, check result and flags
    task automatic alu(input logic [53:0] t);
        op(5'h1a, 5'h18, 6'h00, t[35:28]);
        op(5'h1a, 5'h19, 6'h00, 8'h00);
        bus(1'b1, 8'h04, {26'h0, t[27:22]}, q);
        op(t[53:49], 5'h18, {1'b0, t[48:44]}, t[43:36]);
        bus(1'b0, 8'h0c, 32'h0, q);
        cmp(t[53:49] inside {5'h06, 5'h07, 5'h16, 5'h17} ? q[15:0] : q[7:0], t[21:6]);
        bus(1'b0, 8'h04, 32'h0, q);
        cmp(q[5:0], t[5:0]);
    endtask
    task automatic results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // hang guard, far above the thousand or so cycles needed
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        op(5'h1a, 5'h10, 6'h00, 8'h01);
        op(5'h1a, 5'h11, 6'h00, 8'h80);
        foreach (tc[i]) alu(tc[i]);
        // last row leaves r25:r24 = 00ff; a command written during the word op is dropped
        bus(1'b1, 8'h00, {8'h01, 2'h0, 6'h00, 3'h0, 5'h18, 3'h0, 5'h06}, q);
        op(5'h1a, 5'h18, 6'h00, 8'h44);
        bus(1'b0, 8'h0c, 32'h0, q);
        cmp(q, 32'h0000_0100);
        $display("alu table done");
        req <= 8'h03;
        @(posedge hclk);
        req <= 8'h00;
        bus(1'b0, 8'h10, 32'h0, q);
        cmp(q, 32'h3);
        bus(1'b1, 8'h10, 32'h1, q);
        bus(1'b0, 8'h10, 32'h0, q);
        cmp(q, 32'h2);
        op(5'h19, 5'h00, 6'h20, 8'h00);
        cmp(stat, 32'h2);
        op(5'h19, 5'h00, 6'h1f, 8'h00);
        cmp(stat, 32'h0);
        op(5'h19, 5'h00, 6'h0e, 8'h00);
        cmp(stat, 32'h0);
        bus(1'b0, 8'h10, 32'h0, q);
        cmp(q, 32'h0);
        bus(1'b1, 8'h14, 32'h0000_00ff, q);
        op(5'h18, 5'h00, 6'h0f, 8'h07);
        bus(1'b0, 8'h14, 32'h0, q);
        cmp(q, 32'h0000_007f);
        bus(1'b0, 8'h40, 32'h0, q);
        $display("io flag tests done");
        results();
    end
endmodule
`default_nettype wire

/* File: src/balu_cfg.svh */
// offsets, reset values, constants and io map of the byte alu
`ifndef BALU_CFG_SVH
`define BALU_CFG_SVH

// ----------------------------------------
// bus register byte offsets
// ----------------------------------------
`define BALU_CMD_OFS    8'h00
`define BALU_FLAGS_OFS  8'h04
`define BALU_STAT_OFS   8'h08
`define BALU_RES_OFS    8'h0c
`define BALU_IOFLG_OFS  8'h10
`define BALU_IODAT_OFS  8'h14

// ----------------------------------------
// reset values and constants
// ----------------------------------------
`define BALU_FLAGS_RST  6'h00
`define BALU_IO_RST     8'h00
`define BALU_ALL_ONES   8'hff
`define BALU_HSIZE_WORD 3'h2

// ----------------------------------------
// io space seen by the bit ops
// ----------------------------------------
`define BALU_IO_TOP     6'h1f
`define BALU_IO_FLAG    6'h0e
`define BALU_IO_DATA    6'h0f

`endif

/* File: src/balu_mul.sv */
// registered 8x8 multiplier, signed or unsigned
`timescale 1ns/1ps
`default_nettype none
module balu_mul #(
    parameter int W = 8
) (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic           en,     // capture product
    input  wire logic           sgn,    // both operands signed
    input  wire logic [W-1:0]   a,
    input  wire logic [W-1:0]   b,
    output logic      [2*W-1:0] prod_q
);
    // ----------------------------------------
    // product
    // ----------------------------------------
    logic signed [W:0]     ax;          // sign or zero extended
    logic signed [W:0]     bx;
    logic signed [2*W+1:0] p;

    if (W < 2) begin : g_chk
        $error("balu_mul: W must be at least 2");
    end

    // one extra bit lets one multiplier serve both kinds
    always_comb begin
        ax = $signed({sgn & a[W-1], a});
        bx = $signed({sgn & b[W-1], b});
        p  = (2*W+2)'(ax) * (2*W+2)'(bx);
    end

    // product lands one clock after en
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prod_q <= '0;
        end else if (en) begin
            prod_q <= p[2*W-1:0];
        end
    end
endmodule
`default_nettype wire

/* File: src/balu_pkg.sv */
// types shared by the byte alu files
package balu_pkg;

    // operation codes, numbered in this order from zero
    typedef enum logic [4:0] {
        add_op, add_carry_op, sub_op, subtract_borrow_op,
        subtract_imm_op, subtract_imm_borrow_op,
        word_add_imm_op, word_sub_imm_op,
        and_op, and_imm_op, or_op, or_imm_op, exclusive_or_op,
        bit_set_mask_op, bit_clear_mask_op, zero_minus_test_op,
        ones_complement_op, twos_complement_op,
        increment_op, decrement_op, register_zero_op,
        register_all_ones_op, unsigned_multiply_op,
        signed_multiply_op, io_bit_clear_op, io_bit_set_op,
        load_imm_op, no_op
    } balu_op_t;

    // command word as written by software
    typedef struct packed {
        logic [7:0] imm;
        logic [1:0] pad2;
        logic [5:0] rr;
        logic [2:0] pad1;
        logic [4:0] rd;
        logic [2:0] pad0;
        balu_op_t   op;
    } balu_cmd_t;

    // status flags, bit 0 is carry
    typedef struct packed {
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } balu_flags_t;

    typedef enum logic [1:0] {st_idle, st_read, st_exec, st_exec2} balu_state_t;

endpackage

/* File: src/balu_rf.sv */
// working register file, registered reads, two-byte write port
`timescale 1ns/1ps
`default_nettype none
module balu_rf #(
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire logic [AW-1:0] ra_a,     // read port a address
    input  wire logic [AW-1:0] ra_b,     // read port b address
    output logic      [7:0]    rd_a_q,   // read data a
    output logic      [7:0]    rd_b_q,   // read data b
    input  wire logic          we_lo,    // write wa
    input  wire logic          we_hi,    // write wa+1
    input  wire logic [AW-1:0] wa,
    input  wire logic [7:0]    wd_lo,
    input  wire logic [7:0]    wd_hi
);
    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [7:0]    mem_q [DEPTH];
    logic [AW-1:0] wa_hi;                // pair wraps at the top entry

    assign wa_hi = wa + AW'(1);

    // address width must cover the depth exactly
    if (DEPTH != (1 << AW)) begin : g_chk
        $error("balu_rf: DEPTH must equal 2**AW");
    end

    // one writer per entry, high byte beats low if both hit
    for (genvar i = 0; i < DEPTH; i++) begin : g_ent
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                mem_q[i] <= 8'h00;
            end else if (we_hi && wa_hi == AW'(i)) begin
                mem_q[i] <= wd_hi;
            end else if (we_lo && wa == AW'(i)) begin
                mem_q[i] <= wd_lo;
            end
        end
    end

    // registered read, data one cycle after the address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_a_q <= 8'h00;
            rd_b_q <= 8'h00;
        end else begin
            rd_a_q <= mem_q[ra_a];
            rd_b_q <= mem_q[ra_b];
        end
    end
endmodule
`default_nettype wire

/* File: src/balu_top.sv */
// byte alu datapath with ahb-lite command and status registers
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "balu_cfg.svh"
`default_nettype none
module balu_top
    import balu_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic [7:0]  io_event,   // flag set pulses, same clock
    output logic             alu_busy
);
    // ----------------------------------------
    // bus slave state
    // ----------------------------------------
    logic        dp_wr_q;               // write data phase pending
    logic [7:0]  dp_ad_q;               // its byte offset
    logic        ap_take;               // address phase accepted
    logic        wr_en;                 // write data on hwdata now
    logic [31:0] hrdata_q;
    logic [31:0] rd_mux;

    // ----------------------------------------
    // datapath state
    // ----------------------------------------
    balu_state_t state_q;
    balu_cmd_t   cmd_q;
    balu_flags_t flags_q;
    balu_flags_t fl;                    // flags after a byte op
    balu_flags_t wfl;                   // flags after a word op
    balu_flags_t wfl_q;
    logic [15:0] result_q;              // last value written
    logic [15:0] wide_q;                // word result, written next
    logic [15:0] pair;                  // value for the pair write
    logic [7:0]  io_flag_q;             // write-one-to-clear flags
    logic [7:0]  io_data_q;             // plain io byte
    logic        io_err_q;              // last io op out of range
    logic [7:0]  opa;
    logic [7:0]  opb;
    logic [15:0] prod;
    balu_op_t    op;
    logic        is_mul;
    logic        is_word;
    logic        is_io;

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    // always ready, always okay: every access finishes in one data phase
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign ap_take   = hsel && hready && htrans[1];
    assign wr_en     = dp_wr_q;

    // capture write address; only whole-word writes count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q <= 1'b0;
            dp_ad_q <= 8'h00;
        end else if (hready) begin
            dp_wr_q <= ap_take && hwrite && hsize == `BALU_HSIZE_WORD;
            dp_ad_q <= haddr[7:0];
        end
    end

    // read mux; unmapped offsets read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr[7:0])
            `BALU_CMD_OFS:   rd_mux = cmd_q;
            `BALU_FLAGS_OFS: rd_mux = {26'h0, flags_q};
            `BALU_STAT_OFS:  rd_mux = {30'h0, io_err_q, alu_busy};
            `BALU_RES_OFS:   rd_mux = {16'h0, result_q};
            `BALU_IOFLG_OFS: rd_mux = {24'h0, io_flag_q};
            `BALU_IODAT_OFS: rd_mux = {24'h0, io_data_q};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    // read data is sampled in the address phase, shown in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata_q <= rd_mux;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    assign op       = cmd_q.op;
    assign alu_busy = state_q != st_idle;
    assign is_mul   = op == unsigned_multiply_op || op == signed_multiply_op;
    assign is_word  = op == word_add_imm_op || op == word_sub_imm_op;
    assign is_io    = op == io_bit_clear_op || op == io_bit_set_op;

    // commands written while busy are dropped, not queued
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= st_idle;
            cmd_q   <= '0;
        end else begin
            case (state_q)
                st_idle: begin
                    if (wr_en && dp_ad_q == `BALU_CMD_OFS) begin
                        cmd_q   <= balu_cmd_t'(hwdata);
                        state_q <= st_read;
                    end
                end
                st_read:  state_q <= st_exec;
                st_exec:  state_q <= (is_word || is_mul) ? st_exec2 : st_idle;
                st_exec2: state_q <= st_idle;
                default:  state_q <= st_idle;
            endcase
        end
    end

    // ----------------------------------------
    // byte operations
    // ----------------------------------------
    logic       sub;                     // adder subtracts
    logic       use_c;                   // carry enters the adder
    logic       imm_op;                  // operand b is the constant
    logic       c_eff;
    logic [7:0] a_in;
    logic [7:0] b_in;
    logic [7:0] b_eff;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic [7:0] res;
    logic       ar_c;
    logic       ar_h;
    logic       ar_v;
    logic       upd;                     // z, n, s follow res
    logic       wr;                      // res goes to rd

    // one adder serves add, subtract and negate; subtract adds the inverse
    always_comb begin
        imm_op = op == subtract_imm_op || op == subtract_imm_borrow_op ||
                 op == and_imm_op || op == or_imm_op ||
                 op == bit_set_mask_op || op == bit_clear_mask_op;
        sub    = op == sub_op || op == subtract_borrow_op || op == subtract_imm_op ||
                 op == subtract_imm_borrow_op || op == twos_complement_op;
        use_c  = op == add_carry_op || op == subtract_borrow_op ||
                 op == subtract_imm_borrow_op;
        a_in   = (op == twos_complement_op) ? 8'h00 : opa;
        if (imm_op) begin
            b_in = cmd_q.imm;
        end else if (op == twos_complement_op || op == zero_minus_test_op ||
                     op == register_zero_op) begin
            b_in = opa;
        end else begin
            b_in = opb;
        end
        b_eff = sub ? ~b_in : b_in;
        c_eff = sub ? ~(use_c & flags_q.c) : (use_c & flags_q.c);
        sum9  = {1'b0, a_in} + {1'b0, b_eff} + {8'h00, c_eff};
        nib5  = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
        ar_c  = sum9[8] ^ sub;                                         // carry or borrow
        ar_h  = nib5[4] ^ sub;
        ar_v  = (a_in[7] == b_eff[7]) && (sum9[7] != a_in[7]);
    end

    // result and flags per operation
    always_comb begin
        fl  = flags_q;
        upd = 1'b1;
        wr  = 1'b1;
        res = 8'h00;
        case (op)
            add_op, add_carry_op, sub_op, subtract_borrow_op, subtract_imm_op,
            subtract_imm_borrow_op, twos_complement_op: begin
                res  = sum9[7:0];
                fl.c = ar_c;
                fl.h = ar_h;
                fl.v = ar_v;
            end
            and_op, and_imm_op, zero_minus_test_op: begin
                res  = a_in & b_in;
                fl.v = 1'b0;
            end
            or_op, or_imm_op, bit_set_mask_op: begin
                res  = a_in | b_in;
                fl.v = 1'b0;
            end
            bit_clear_mask_op: begin
                res  = a_in & (`BALU_ALL_ONES - b_in);
                fl.v = 1'b0;
            end
            exclusive_or_op, register_zero_op: begin
                res  = a_in ^ b_in;
                fl.v = 1'b0;
            end
            ones_complement_op: begin
                res  = `BALU_ALL_ONES - opa;
                fl.c = 1'b1;
                fl.v = 1'b0;
            end
            increment_op: begin
                res  = opa + 8'h01;
                fl.v = opa == 8'h7f;
            end
            decrement_op: begin
                res  = opa - 8'h01;
                fl.v = opa == 8'h80;
            end
            register_all_ones_op: begin
                res = `BALU_ALL_ONES;
                upd = 1'b0;
            end
            load_imm_op: begin
                res = cmd_q.imm;
                upd = 1'b0;
            end
            default: begin
                wr  = 1'b0;
                upd = 1'b0;
            end
        endcase
        if (upd) begin
            fl.z = res == 8'h00;
            fl.n = res[7];
            fl.s = fl.n ^ fl.v;
        end
    end

    // ----------------------------------------
    // word operations
    // ----------------------------------------
    logic [15:0] w_in;
    logic [16:0] w17;

    // k is six bits wide; the pair is rd+1:rd
    always_comb begin
        w_in  = {opb, opa};
        if (op == word_add_imm_op) begin
            w17   = {1'b0, w_in} + {11'h000, cmd_q.imm[5:0]};
            wfl.v = ~w_in[15] & w17[15];
        end else begin
            w17   = {1'b0, w_in} - {11'h000, cmd_q.imm[5:0]};
            wfl.v = w_in[15] & ~w17[15];
        end
        wfl.c = w17[16];
        wfl.n = w17[15];
        wfl.z = w17[15:0] == 16'h0000;
        wfl.s = wfl.n ^ wfl.v;
        wfl.h = flags_q.h;
    end

    // word result waits one clock so both halves go in together
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wide_q <= 16'h0000;
            wfl_q  <= '0;
        end else if (state_q == st_exec && is_word) begin
            wide_q <= w17[15:0];
            wfl_q  <= wfl;
        end
    end

    assign pair = is_mul ? prod : wide_q;

    // ----------------------------------------
    // io bit operations
    // ----------------------------------------
    logic       io_ok;                   // address inside the bit-op range
    logic [7:0] io_cur;
    logic [7:0] io_new;
    logic [7:0] io_mask;
    logic       io_go;
    logic [7:0] flag_clr;

    always_comb begin
        io_ok   = cmd_q.rr <= `BALU_IO_TOP;
        io_go   = state_q == st_exec && is_io && io_ok;
        io_mask = 8'h01 << cmd_q.imm[2:0];
        case (cmd_q.rr)
            `BALU_IO_FLAG: io_cur = io_flag_q;
            `BALU_IO_DATA: io_cur = io_data_q;
            default:       io_cur = 8'h00;
        endcase
        // whole byte goes back, so set flags clear themselves
        io_new = (op == io_bit_set_op) ? (io_cur | io_mask) : (io_cur & ~io_mask);
        flag_clr = 8'h00;
        if (io_go && cmd_q.rr == `BALU_IO_FLAG) begin
            flag_clr = io_new;
        end
        if (wr_en && dp_ad_q == `BALU_IOFLG_OFS) begin
            flag_clr = flag_clr | hwdata[7:0];
        end
    end

    // flag bits: a one clears, a zero leaves; a new event beats the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_flag_q <= `BALU_IO_RST;
        end else begin
            io_flag_q <= (io_flag_q & ~flag_clr) | io_event;
        end
    end

    // plain io byte, written by the bus or by a bit op
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_data_q <= `BALU_IO_RST;
        end else if (io_go && cmd_q.rr == `BALU_IO_DATA) begin
            io_data_q <= io_new;
        end else if (wr_en && dp_ad_q == `BALU_IODAT_OFS) begin
            io_data_q <= hwdata[7:0];
        end
    end

    // out-of-range bit ops do nothing but raise this
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_err_q <= 1'b0;
        end else if (state_q == st_exec && is_io) begin
            io_err_q <= !io_ok;
        end
    end

    // ----------------------------------------
    // flags and result
    // ----------------------------------------
    // alu updates win over a bus write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= `BALU_FLAGS_RST;
        end else if (state_q == st_exec && upd) begin
            flags_q <= fl;
        end else if (state_q == st_exec2 && is_mul) begin
            flags_q.c <= prod[15];
            flags_q.z <= prod == 16'h0000;
        end else if (state_q == st_exec2) begin
            flags_q <= wfl_q;
        end else if (wr_en && dp_ad_q == `BALU_FLAGS_OFS) begin
            flags_q <= balu_flags_t'(hwdata[5:0]);
        end
    end

    // last value written to the register file
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_q <= 16'h0000;
        end else if (state_q == st_exec && wr) begin
            result_q <= {8'h00, res};
        end else if (state_q == st_exec2) begin
            result_q <= pair;
        end
    end

    // ----------------------------------------
    // register file and multiplier
    // ----------------------------------------
    logic       we_lo;
    logic       we_hi;
    logic [4:0] wa;
    logic [4:0] ra_b;

    assign ra_b  = is_word ? cmd_q.rd + 5'd1 : cmd_q.rr[4:0];
    assign we_lo = (state_q == st_exec && wr) || state_q == st_exec2;
    assign we_hi = state_q == st_exec2;
    assign wa    = (state_q == st_exec2 && is_mul) ? 5'd0 : cmd_q.rd;

    balu_rf #(
        .DEPTH (32),
        .AW    (5)
    ) u_rf (
        .clk    (hclk),
        .rst_n  (hresetn),
        .ra_a   (cmd_q.rd),
        .ra_b   (ra_b),
        .rd_a_q (opa),
        .rd_b_q (opb),
        .we_lo  (we_lo),
        .we_hi  (we_hi),
        .wa     (wa),
        .wd_lo  (state_q == st_exec2 ? pair[7:0] : res),
        .wd_hi  (pair[15:8])
    );

    balu_mul #(
        .W (8)
    ) u_mul (
        .clk    (hclk),
        .rst_n  (hresetn),
        .en     (state_q == st_exec && is_mul),
        .sgn    (op == signed_multiply_op),
        .a      (opa),
        .b      (opb),
        .prod_q (prod)
    );

endmodule
`default_nettype wire
